//--- logic/lfwdt_top.v
// low-frequency watchdog: start-value register, byte pointer and countdown
// assumes a byte register port with read data one cycle after the read strobe,
// and a 32.768 kHz clock input synchronous to clk_sys
`include "lfwdt_consts.vh"
`default_nettype none

module lfwdt_top (
    input  wire                       clk_sys,
    input  wire                       rst_b,
    input  wire [`LFWDT_ADDR_W-1:0]   reg_addr,
    input  wire [`LFWDT_DATA_W-1:0]   reg_wdata,
    input  wire                       reg_wr,
    input  wire                       reg_rd,
    output wire [`LFWDT_DATA_W-1:0]   reg_rdata,
    input  wire                       lf_clk,
    input  wire                       retention_entry,
    output wire                       wdog_running,
    output wire                       wdog_sys_reset
);

    ////////////////////////////////////////////////////////////////////////////
    // reset release

    reg rst_meta_reg;
    reg rst_sync_reg;

    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    wire rst_n_sync;

    assign rst_n_sync = rst_sync_reg;

    ////////////////////////////////////////////////////////////////////////////
    // state

    reg  [`LFWDT_SV_W-1:0]     sv_reg;
    reg  [`LFWDT_SV_W-1:0]     sv_next;
    reg  [`LFWDT_DATA_W-1:0]   low_byte_reg;
    reg  [`LFWDT_DATA_W-1:0]   low_byte_next;
    reg                        ptr_high_reg;
    reg                        ptr_high_next;
    reg                        last_was_read_reg;
    reg                        last_was_read_next;
    reg                        running_reg;
    reg                        running_next;
    reg  [`LFWDT_DATA_W-1:0]   rdata_reg;
    reg  [`LFWDT_DATA_W-1:0]   rdata_next;
    reg  [`LFWDT_RST_CNT_W-1:0] rst_cnt_reg;
    reg  [`LFWDT_RST_CNT_W-1:0] rst_cnt_next;
    reg                        sys_reset_reg;
    reg                        sys_reset_next;
    reg                        load_now;

    wire                       hit;
    wire                       wr_hit;
    wire                       rd_hit;
    wire                       ptr_eff;
    wire                       lf_tick;
    wire                       expire;

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    assign hit    = (reg_addr == `LFWDT_ADDR_START_VAL);
    assign wr_hit = reg_wr && hit;
    assign rd_hit = reg_rd && hit;

    // a change of direction points back at the low byte before the access
    assign ptr_eff = ptr_high_reg &&
                     ((wr_hit && !last_was_read_reg) || (rd_hit && last_was_read_reg));

    ////////////////////////////////////////////////////////////////////////////
    // low-frequency tick and counter

    lfwdt_edge u_edge (
        .clk_sys    (clk_sys),
        .rst_n_sync (rst_n_sync),
        .lf_clk     (lf_clk),
        .lf_tick    (lf_tick)
    );

    lfwdt_counter u_counter (
        .clk_sys     (clk_sys),
        .rst_n_sync  (rst_n_sync),
        .load        (load_now),
        .start_value (sv_next),
        .run         (running_reg),
        .lf_tick     (lf_tick),
        .expire      (expire)
    );

    ////////////////////////////////////////////////////////////////////////////
    // register access and watchdog control

    always @* begin
        sv_next            = sv_reg;
        low_byte_next      = low_byte_reg;
        ptr_high_next      = ptr_high_reg;
        last_was_read_next = last_was_read_reg;
        running_next       = running_reg;
        rdata_next         = `LFWDT_BYTE_ZERO;
        load_now           = 1'b0;

        if (wr_hit) begin
            last_was_read_next = 1'b0;
            if (!ptr_eff) begin
                // held aside so the running countdown is untouched
                low_byte_next = reg_wdata;
                ptr_high_next = 1'b1;
            end else begin
                sv_next       = {reg_wdata, low_byte_reg};
                ptr_high_next = 1'b0;
                load_now      = 1'b1;
                running_next  = 1'b1;
            end
        end else if (rd_hit) begin
            last_was_read_next = 1'b1;
            // the programmed value, not the live count
            if (!ptr_eff) begin
                rdata_next    = sv_reg[`LFWDT_DATA_W-1:0];
                ptr_high_next = 1'b1;
            end else begin
                rdata_next    = sv_reg[`LFWDT_SV_W-1:`LFWDT_DATA_W];
                ptr_high_next = 1'b0;
            end
        end

        // power-down into a retention mode halts the countdown
        if (retention_entry) begin
            running_next = 1'b0;
            load_now     = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // system reset request

    always @* begin
        rst_cnt_next   = rst_cnt_reg;
        sys_reset_next = sys_reset_reg;
        if (expire && !retention_entry) begin
            rst_cnt_next   = `LFWDT_RST_PULSE;
            sys_reset_next = 1'b1;
        end else if (rst_cnt_reg != `LFWDT_RST_CNT_ZERO) begin
            rst_cnt_next   = rst_cnt_reg - `LFWDT_RST_CNT_ONE;
            sys_reset_next = (rst_cnt_reg != `LFWDT_RST_CNT_ONE);
        end
    end

    always @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            sv_reg            <= `LFWDT_SV_RESET;
            low_byte_reg      <= `LFWDT_BYTE_ZERO;
            ptr_high_reg      <= 1'b0;
            last_was_read_reg <= 1'b0;
            running_reg       <= 1'b0;
            rdata_reg         <= `LFWDT_BYTE_ZERO;
            rst_cnt_reg       <= `LFWDT_RST_CNT_ZERO;
            sys_reset_reg     <= 1'b0;
        end else if (expire && !retention_entry) begin
            // the timeout returns start value, byte pointer and run flag to their power-on values
            sv_reg            <= `LFWDT_SV_RESET;
            low_byte_reg      <= `LFWDT_BYTE_ZERO;
            ptr_high_reg      <= 1'b0;
            last_was_read_reg <= 1'b0;
            running_reg       <= 1'b0;
            rdata_reg         <= rdata_next;
            rst_cnt_reg       <= rst_cnt_next;
            sys_reset_reg     <= sys_reset_next;
        end else begin
            sv_reg            <= sv_next;
            low_byte_reg      <= low_byte_next;
            ptr_high_reg      <= ptr_high_next;
            last_was_read_reg <= last_was_read_next;
            running_reg       <= running_next;
            rdata_reg         <= rdata_next;
            rst_cnt_reg       <= rst_cnt_next;
            sys_reset_reg     <= sys_reset_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs

    assign reg_rdata      = rdata_reg;
    assign wdog_running   = running_reg;
    assign wdog_sys_reset = sys_reset_reg;

endmodule

`default_nettype wire

//--- logic/lfwdt_consts.vh
// constants shared by the low-frequency watchdog design files
// assumes it is included by bare name from files under logic/
`ifndef LFWDT_CONSTS_VH
`define LFWDT_CONSTS_VH

`define LFWDT_ADDR_W          8
`define LFWDT_DATA_W          8
`define LFWDT_SV_W            16
`define LFWDT_CNT_W           24
`define LFWDT_OFFSET_W        8

`define LFWDT_ADDR_START_VAL  8'hAF
`define LFWDT_SV_RESET        16'h0000
`define LFWDT_OFFSET_BITS     8'h00
`define LFWDT_CNT_ZERO        24'h000000
`define LFWDT_CNT_LAST        24'h000001
`define LFWDT_BYTE_ZERO       8'h00

// low-frequency clock rate in Hz, and timeout step in ticks of that clock
`define LFWDT_LF_HZ           32768
`define LFWDT_TICKS_PER_STEP  256

// length of the system reset request, in clk_sys cycles
`define LFWDT_RST_PULSE       4'hF
`define LFWDT_RST_CNT_W       4
`define LFWDT_RST_CNT_ZERO    4'h0
`define LFWDT_RST_CNT_ONE     4'h1

`endif

//--- logic/lfwdt_edge.v
// rising-edge detector for the low-frequency clock input
// assumes lf_clk is already synchronous to clk_sys
`default_nettype none

module lfwdt_edge (
    input  wire clk_sys,
    input  wire rst_n_sync,
    input  wire lf_clk,
    output wire lf_tick
);

    reg lf_clk_reg;

    always @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            lf_clk_reg <= 1'b0;
        end else begin
            lf_clk_reg <= lf_clk;
        end
    end

    // one clk_sys cycle per low-frequency period
    assign lf_tick = lf_clk & ~lf_clk_reg;

endmodule

`default_nettype wire

//--- logic/lfwdt_counter.v
// 24-bit watchdog down-counter with load and timeout detect
// assumes load and stop never coincide with a need to keep counting
`include "lfwdt_consts.vh"
`default_nettype none

module lfwdt_counter (
    input  wire                      clk_sys,
    input  wire                      rst_n_sync,
    input  wire                      load,
    input  wire [`LFWDT_SV_W-1:0]    start_value,
    input  wire                      run,
    input  wire                      lf_tick,
    output wire                      expire
);

    reg  [`LFWDT_CNT_W-1:0] cnt_reg;
    reg  [`LFWDT_CNT_W-1:0] cnt_next;

    always @* begin
        cnt_next = cnt_reg;
        if (load) begin
            cnt_next = {start_value, `LFWDT_OFFSET_BITS};
        end else if (run && lf_tick) begin
            // zero wraps to all ones, giving the full 2^24 count
            cnt_next = cnt_reg - `LFWDT_CNT_LAST;
        end
    end

    always @(posedge clk_sys or negedge rst_n_sync) begin
        if (!rst_n_sync) begin
            cnt_reg <= `LFWDT_CNT_ZERO;
        end else begin
            cnt_reg <= cnt_next;
        end
    end

    // fires on the tick that takes the count from one to zero
    assign expire = run && !load && lf_tick && (cnt_reg == `LFWDT_CNT_LAST);

endmodule

`default_nettype wire

//--- sim/lfwdt_sva.sv
// checker for the low-frequency watchdog, watching only the top ports
// assumes one clk_sys domain and bind onto lfwdt_top
`default_nettype none
module lfwdt_sva (
    input wire logic       clk_sys,
    input wire logic       rst_b,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       lf_clk,
    input wire logic       retention_entry,
    input wire logic       wdog_running,
    input wire logic       wdog_sys_reset
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0]  hi_cnt;
    logic [19:0] tick_cnt;
    logic        lf_prev;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    ////////////////////////////////////////////////////////////
    // ticks since the last write; a lone low write only makes the bound stricter
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hi_cnt   <= 5'h00;
            tick_cnt <= 20'h00000;
            lf_prev  <= 1'b0;
        end else begin
            hi_cnt   <= wdog_sys_reset ? hi_cnt + 5'h01 : 5'h00;
            tick_cnt <= (reg_wr && reg_addr == 8'hAF) ? 20'h00000 : tick_cnt + {19'h00000, lf_clk & ~lf_prev};
            lf_prev  <= lf_clk;
        end
    end
    a_rdata_idle: assert property (!($past(reg_rd) && $past(reg_addr) == 8'hAF) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read answer");
    a_start_by_write: assert property ($rose(wdog_running) |-> $past(reg_wr) && $past(reg_addr) == 8'hAF)
        else $error("watchdog started without a register write");
    a_write_no_stop: assert property ($fell(wdog_running) |-> wdog_sys_reset || $past(retention_entry))
        else $error("watchdog stopped without timeout or retention");
    a_retention_stop: assert property (retention_entry |=> !wdog_running)
        else $error("retention entry did not stop the watchdog");
    a_reset_cause: assert property ($rose(wdog_sys_reset) |-> $past(wdog_running) && !wdog_running)
        else $error("reset request without a running countdown");
    a_min_ticks: assert property ($rose(wdog_sys_reset) |-> tick_cnt >= 20'h00100)
        else $error("timeout before 256 low-frequency ticks");
    a_pulse_len: assert property ($fell(wdog_sys_reset) |-> hi_cnt == 5'h0F)
        else $error("reset request not 15 cycles long");
    a_req_idle: assert property (wdog_sys_reset |-> !wdog_running)
        else $error("watchdog running during reset request");
endmodule
bind lfwdt_top lfwdt_sva u_sva (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lf_clk(lf_clk),
    .retention_entry(retention_entry), .wdog_running(wdog_running), .wdog_sys_reset(wdog_sys_reset));
`default_nettype wire

//--- sim/tb.sv
// self-checking bench for the low-frequency watchdog top
// assumes lfwdt_top from logic/ with the checker bound onto it
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys;
    logic        rst_b;
    logic [7:0]  reg_addr;
    logic [7:0]  reg_wdata;
    logic        reg_wr;
    logic        reg_rd;
    logic [7:0]  reg_rdata;
    logic        lf_clk;
    logic        retention_entry;
    logic        wdog_running;
    logic        wdog_sys_reset;
    int          errors;
    int          num_checks;
    logic [15:0] rows [4] = '{16'h1234, 16'hA55A, 16'h0000, 16'hFFFF};
    lfwdt_top DUT (.clk_sys(clk_sys), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lf_clk(lf_clk),
        .retention_entry(retention_entry), .wdog_running(wdog_running), .wdog_sys_reset(wdog_sys_reset));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        @(negedge clk_sys);
        d = reg_rdata;
    endtask
    task automatic wsv(input logic [15:0] v);
        wr(8'hAF, v[7:0]);
        wr(8'hAF, v[15:8]);
    endtask
    task automatic rsv(output logic [15:0] v);
        rd(8'hAF, v[7:0]);
        rd(8'hAF, v[15:8]);
    endtask
    // one slow tick; the margin lets a registered edge detector add a cycle
    task automatic tick();
        @(posedge clk_sys);
        lf_clk <= 1'b1;
        @(posedge clk_sys);
        lf_clk <= 1'b0;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask
    task automatic report_and_stop();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    initial begin
        logic [15:0] v;
        logic [7:0]  b;
        int          n;
        errors = 0;
        num_checks = 0;
        rst_b = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        lf_clk = 1'b0;
        retention_entry = 1'b0;
        repeat (12) @(posedge clk_sys);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rsv(v);
        chk(v, 16'h0000);
        chk({15'h0000, wdog_running}, 16'h0000);
        // a lone low byte neither starts the count nor shows on read
        wr(8'hAF, 8'h34);
        rsv(v);
        chk(v, 16'h0000);
        chk({15'h0000, wdog_running}, 16'h0000);
        for (int i = 0; i < 4; i++) begin
            wsv(rows[i]);
            rsv(v);
            chk(v, rows[i]);
            chk({15'h0000, wdog_running}, 16'h0001);
        end
        wr(8'hAE, 8'h55);
        rd(8'hAE, b);
        chk({8'h00, b}, 16'h0000);
        // half a read, then a write pair must restart at the low byte
        rd(8'hAF, b);
        chk({8'h00, b}, 16'h00FF);
        wsv(16'h0302);
        rsv(v);
        chk(v, 16'h0302);
        @(posedge clk_sys);
        retention_entry <= 1'b1;
        @(posedge clk_sys);
        retention_entry <= 1'b0;
        @(negedge clk_sys);
        chk({15'h0000, wdog_running}, 16'h0000);
        wsv(16'h0001);
        repeat (200) tick();
        wsv(16'h0001);
        for (n = 1; n <= 600; n++) begin
            tick();
            if (wdog_sys_reset === 1'b1) break;
        end
        chk(16'(n), 16'h0100);
        if (n > 600) report_and_stop();
        chk({15'h0000, wdog_running}, 16'h0000);
        repeat (20) @(posedge clk_sys);
        rsv(v);
        chk(v, 16'h0000);
        report_and_stop();
    end
endmodule
`default_nettype wire
